// >>> include/ddslc_pkg.sv
// Shared constants and types for the dual converter serial load link.
// Assumes a single 250 MHz system clock at both ends of the link.
package ddslc_pkg;
  // Command word layout
  localparam int WORD_W       = 16;
  localparam int CODE_W       = 10;
  localparam int CNT_W        = 4;
  localparam int POS_LEAD_HI  = 15;
  localparam int POS_LEAD_LO  = 14;
  localparam int POS_MODE_HI  = 13;
  localparam int POS_MODE_LO  = 12;
  localparam int POS_CODE_MSB = 11;
  localparam int POS_CODE_LSB = 2;
  localparam logic [CNT_W-1:0]  LAST_BIT = 4'hf;
  localparam logic [CODE_W-1:0] CODE_RST = 10'h000;

  // Timing, in picoseconds, microseconds and system clock cycles
  localparam int CLK_PS        = 4000;
  localparam int SCLK_MIN_PS   = 25000;
  localparam int HALF_MIN_CYC  = (SCLK_MIN_PS / 2 + CLK_PS - 1) / CLK_PS;
  localparam int SYNC_HIGH_PS  = 10000;
  localparam int SYNC_HIGH_CYC = (SYNC_HIGH_PS + CLK_PS - 1) / CLK_PS;
  localparam int WAKE_US       = 6;
  localparam int WAKE_CYC      = WAKE_US * 1000000 / CLK_PS;

  // Host register map (byte addresses) and reset values
  localparam int ADDR_W = 4;
  localparam int DIV_W  = 8;
  localparam logic [ADDR_W-1:0] REG_CMD  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
  localparam logic [ADDR_W-1:0] REG_DIV  = 4'h8;
  localparam logic [DIV_W-1:0]  DIV_RST  = 8'h10;
  localparam logic [DIV_W-1:0]  DIV_MIN  = 8'h04;

  typedef enum logic [1:0] {
    MODE_LOAD     = 2'h0,
    MODE_LOAD_UPD = 2'h1,
    MODE_BOTH_UPD = 2'h2,
    MODE_PWRDN    = 2'h3
  } ddslc_mode_t;

  typedef enum logic [1:0] {
    DEV_IDLE  = 2'h0,
    DEV_SHIFT = 2'h1,
    DEV_DONE  = 2'h3
  } ddslc_dev_st_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_SETUP = 3'h1,
    H_LOW   = 3'h3,
    H_HIGH  = 3'h2,
    H_TAIL  = 3'h6,
    H_GAP   = 3'h7
  } ddslc_host_st_t;
endpackage

// >>> include/ddslc_link_if.sv
// Three-wire serial link between the host end and the converter end.
// Assumes the host drives all three wires; the converter only listens.
interface ddslc_link_if;
  logic frameSelN;
  logic serClk;
  logic serData;

  modport host (
    output frameSelN,
    output serClk,
    output serData
  );

  modport dev (
    input frameSelN,
    input serClk,
    input serData
  );
endinterface

// >>> rtl/ddslc_sync.sv
// Two-stage synchroniser for a group of asynchronous levels.
// Assumes inputs may change at any time relative to clk.
module ddslc_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_q  <= '0;
      syncOut <= '0;
    end else begin
      meta_q  <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule

// >>> rtl/ddslc_dev.sv
// Converter end: serial word capture, command decode, channel registers.
// Assumes the link wires come from another clock domain and are
// synchronised here; analog outputs are represented by codes and flags.
// Summary of operation
// - Shift data on serial clock falls while selected
// - Host opens each frame by lowering select
// - Host never lowers select on clock fall
// - Sixteenth fall captures last bit, executes command
// - Ignore clocks after sixteenth until select rises
// - Host may hold or raise select after
// - Host keeps select high minimum time between
// - Host idles select high and data low
// - Host sends zero as first bit
// - Second bit picks channel A or B
// - Two mode bits choose one of four operations
// - Last twelve bits are data, MSB first; code keeps only bits 11 to 2 as the ten-bit value
// - Channel registers hold codes 0 to 1023
// - Early select rise aborts frame, nothing changes
// - Reset clears registers, outputs zero until write
// - Mode 11 powers down both outputs
// - Lead bits choose power-down output termination
// - Power-down keeps channel register contents
// - Exit keeps old values unless frame loads
// - Serial clock at most 40 MHz
// - Wake interval from sixteenth fall, then output
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
module ddslc_dev (
  input  wire logic          clk,
  input  wire logic          sys_rst,
  ddslc_link_if.dev          link,
  output logic [9:0]         channelAOutput_q,
  output logic [9:0]         channelBOutput_q,
  output logic               powerDown_q,
  output logic               termHiZ_q,
  output logic               termPull2k5_q,
  output logic               termPull100k_q,
  output logic               frameDone_q
);
  localparam int WAKE_W = $clog2(ddslc_pkg::WAKE_CYC + 1);
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(ddslc_pkg::WAKE_CYC);

  logic [2:0]                       linkSync;
  logic                             selN;
  logic                             sclk;
  logic                             din;
  logic                             selN_q;
  logic                             sclk_q;
  logic                             selFall;
  logic                             selRise;
  logic                             sclkFall;
  ddslc_pkg::ddslc_dev_st_t         state_q;
  logic [ddslc_pkg::CNT_W-1:0]      bitCnt_q;
  logic [ddslc_pkg::WORD_W-2:0]     shift_q;
  logic [ddslc_pkg::WORD_W-1:0]     word;
  logic                             exec;
  logic                             leadBitHi;
  logic                             leadBitLo;
  ddslc_pkg::ddslc_mode_t           mode;
  logic [ddslc_pkg::CODE_W-1:0]     code;
  logic [ddslc_pkg::CODE_W-1:0]     inA_q;
  logic [ddslc_pkg::CODE_W-1:0]     inB_q;
  logic [ddslc_pkg::CODE_W-1:0]     dacA_q;
  logic [ddslc_pkg::CODE_W-1:0]     dacB_q;
  logic [ddslc_pkg::CODE_W-1:0]     nextInA;
  logic [ddslc_pkg::CODE_W-1:0]     nextInB;
  logic                             live_q;
  logic                             waking_q;
  logic [WAKE_W-1:0]                wakeCnt_q;
  logic                             showOut;

  // Link wires cross into the system clock domain; select and clock pass
  // inverted so a cleared synchroniser reads as the idle high level
  ddslc_sync #(
    .W (3)
  ) u_sync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .asyncIn ({~link.frameSelN, ~link.serClk, link.serData}),
    .syncOut (linkSync)
  );
  assign selN = ~linkSync[2];
  assign sclk = ~linkSync[1];
  assign din  = linkSync[0];

  // Edge history of synchronised select and clock
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      selN_q <= 1'b1;
      sclk_q <= 1'b1;
    end else begin
      selN_q <= selN;
      sclk_q <= sclk;
    end
  end
  assign selFall  = selN_q & ~selN;
  assign selRise  = ~selN_q & selN;
  assign sclkFall = sclk_q & ~sclk;

  // Frame state: idle, shifting, finished until select rises
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ddslc_pkg::DEV_IDLE;
    end else begin
      case (state_q)
        ddslc_pkg::DEV_IDLE: begin
          if (selFall) begin
            state_q <= ddslc_pkg::DEV_SHIFT;
          end
        end
        ddslc_pkg::DEV_SHIFT: begin
          if (selRise) begin
            state_q <= ddslc_pkg::DEV_IDLE;
          end else if (sclkFall && bitCnt_q == ddslc_pkg::LAST_BIT) begin
            state_q <= ddslc_pkg::DEV_DONE;
          end
        end
        ddslc_pkg::DEV_DONE: begin
          if (selRise) begin
            state_q <= ddslc_pkg::DEV_IDLE;
          end
        end
        default: begin
          state_q <= ddslc_pkg::DEV_IDLE;
        end
      endcase
    end
  end

  // Bit counter and input shift register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCnt_q <= '0;
      shift_q  <= '0;
    end else if (state_q != ddslc_pkg::DEV_SHIFT) begin
      bitCnt_q <= '0;
    end else if (sclkFall && !selRise) begin
      bitCnt_q <= bitCnt_q + 4'h1;
      shift_q  <= {shift_q[ddslc_pkg::WORD_W-3:0], din};
    end
  end

  // Decode of the completed word
  assign exec      = (state_q == ddslc_pkg::DEV_SHIFT) && sclkFall && !selRise
                     && (bitCnt_q == ddslc_pkg::LAST_BIT);
  assign word      = {shift_q, din};
  assign leadBitHi = word[ddslc_pkg::POS_LEAD_HI];
  assign leadBitLo = word[ddslc_pkg::POS_LEAD_LO];
  assign mode      = ddslc_pkg::ddslc_mode_t'(word[ddslc_pkg::POS_MODE_HI:ddslc_pkg::POS_MODE_LO]);
  assign code      = word[ddslc_pkg::POS_CODE_MSB:ddslc_pkg::POS_CODE_LSB];

  // Input register values after the command
  always_comb begin
    nextInA = inA_q;
    nextInB = inB_q;
    case (mode)
      ddslc_pkg::MODE_LOAD, ddslc_pkg::MODE_LOAD_UPD: begin
        if (leadBitLo) begin
          nextInB = code;
        end else begin
          nextInA = code;
        end
      end
      ddslc_pkg::MODE_BOTH_UPD: begin
        nextInA = code;
        nextInB = code;
      end
      default: begin
        nextInA = inA_q;
        nextInB = inB_q;
      end
    endcase
  end

  // Input and converter registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      inA_q  <= ddslc_pkg::CODE_RST;
      inB_q  <= ddslc_pkg::CODE_RST;
      dacA_q <= ddslc_pkg::CODE_RST;
      dacB_q <= ddslc_pkg::CODE_RST;
    end else if (exec) begin
      inA_q <= nextInA;
      inB_q <= nextInB;
      if (mode == ddslc_pkg::MODE_LOAD_UPD || mode == ddslc_pkg::MODE_BOTH_UPD) begin
        dacA_q <= nextInA;
        dacB_q <= nextInB;
      end
    end
  end

  // Power-down state and termination choice
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      powerDown_q    <= 1'b0;
      termHiZ_q      <= 1'b0;
      termPull2k5_q  <= 1'b0;
      termPull100k_q <= 1'b0;
    end else if (exec) begin
      powerDown_q    <= (mode == ddslc_pkg::MODE_PWRDN);
      termHiZ_q      <= (mode == ddslc_pkg::MODE_PWRDN) && (leadBitHi == leadBitLo);
      termPull2k5_q  <= (mode == ddslc_pkg::MODE_PWRDN) && !leadBitHi && leadBitLo;
      termPull100k_q <= (mode == ddslc_pkg::MODE_PWRDN) && leadBitHi && !leadBitLo;
    end
  end

  // Wake interval after leaving power-down
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      live_q    <= 1'b0;
      waking_q  <= 1'b0;
      wakeCnt_q <= '0;
    end else if (exec && mode == ddslc_pkg::MODE_PWRDN) begin
      live_q   <= 1'b0;
      waking_q <= 1'b0;
    end else if (exec && powerDown_q) begin
      waking_q  <= 1'b1;
      wakeCnt_q <= '0;
    end else if (exec && !waking_q) begin
      live_q <= 1'b1;
    end else if (waking_q) begin
      wakeCnt_q <= wakeCnt_q + WAKE_W'(1);
      if (wakeCnt_q == WAKE_LAST - WAKE_W'(1)) begin
        waking_q <= 1'b0;
        live_q   <= 1'b1;
      end
    end
  end

  // Outputs drop in the same cycle that power-down is flagged
  assign showOut = live_q && !(exec && mode == ddslc_pkg::MODE_PWRDN);

  // Output levels: zero until live
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      channelAOutput_q <= ddslc_pkg::CODE_RST;
      channelBOutput_q <= ddslc_pkg::CODE_RST;
      frameDone_q      <= 1'b0;
    end else begin
      channelAOutput_q <= showOut ? dacA_q : ddslc_pkg::CODE_RST;
      channelBOutput_q <= showOut ? dacB_q : ddslc_pkg::CODE_RST;
      frameDone_q      <= exec;
    end
  end
endmodule

// >>> rtl/ddslc_host.sv
// Host end: Avalon-MM register slave that sends one 16-bit frame per
// command write accepted while idle. Assumes the bus master honours waitrequest.
module ddslc_host (
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  input  wire logic [ddslc_pkg::ADDR_W-1:0]  address,
  input  wire logic                          read,
  input  wire logic                          write,
  input  wire logic [31:0]                   writedata,
  output logic      [31:0]                   readdata,
  output logic                               waitrequest,
  ddslc_link_if.host                         link
);
  ddslc_pkg::ddslc_host_st_t          state_q;
  logic [ddslc_pkg::WORD_W-1:0]       cmd_q;
  logic [ddslc_pkg::WORD_W-1:0]       out_q;
  logic [ddslc_pkg::DIV_W-1:0]        div_q;
  logic [ddslc_pkg::DIV_W-1:0]        timer_q;
  logic [ddslc_pkg::CNT_W-1:0]        bitCnt_q;
  logic                               refused_q;
  logic                               selN_q;
  logic                               sclk_q;
  logic                               data_q;
  logic                               accept;
  logic                               start;
  logic                               tick;

  assign accept = (read | write) & ~waitrequest;
  assign start  = accept & write & (address == ddslc_pkg::REG_CMD)
                  & (state_q == ddslc_pkg::H_IDLE);
  assign tick   = (timer_q == '0);

  // One wait cycle, then a single ready cycle
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
    end
  end

  // Register writes and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_q     <= '0;
      div_q     <= ddslc_pkg::DIV_RST;
      refused_q <= 1'b0;
      readdata  <= '0;
    end else begin
      if (start) begin
        cmd_q <= writedata[ddslc_pkg::WORD_W-1:0];
      end else if (accept && write && address == ddslc_pkg::REG_CMD) begin
        refused_q <= 1'b1;
      end else if (accept && write && address == ddslc_pkg::REG_STAT) begin
        refused_q <= refused_q & ~writedata[1];
      end
      if (accept && write && address == ddslc_pkg::REG_DIV) begin
        div_q <= (writedata[ddslc_pkg::DIV_W-1:0] < ddslc_pkg::DIV_MIN) ?
                 ddslc_pkg::DIV_MIN : writedata[ddslc_pkg::DIV_W-1:0];
      end
      if (!waitrequest) begin
        readdata <= '0;
      end else if (read && address == ddslc_pkg::REG_CMD) begin
        readdata <= {16'h0000, cmd_q};
      end else if (read && address == ddslc_pkg::REG_STAT) begin
        readdata <= {30'h0, refused_q, state_q != ddslc_pkg::H_IDLE};
      end else if (read && address == ddslc_pkg::REG_DIV) begin
        readdata <= {24'h000000, div_q};
      end else begin
        readdata <= '0;
      end
    end
  end

  // Frame sequencer with half-period timer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q  <= ddslc_pkg::H_IDLE;
      timer_q  <= '0;
      bitCnt_q <= '0;
      out_q    <= '0;
      selN_q   <= 1'b1;
      sclk_q   <= 1'b1;
      data_q   <= 1'b0;
    end else begin
      timer_q <= tick ? '0 : timer_q - ddslc_pkg::DIV_W'(1);
      case (state_q)
        ddslc_pkg::H_IDLE: begin
          if (start) begin
            out_q    <= {1'b0, writedata[ddslc_pkg::WORD_W-2:0]};
            data_q   <= 1'b0;
            selN_q   <= 1'b0;
            bitCnt_q <= '0;
            timer_q  <= div_q;
            state_q  <= ddslc_pkg::H_SETUP;
          end
        end
        ddslc_pkg::H_SETUP, ddslc_pkg::H_HIGH: begin
          if (tick) begin
            sclk_q  <= 1'b0;
            timer_q <= div_q;
            state_q <= ddslc_pkg::H_LOW;
          end
        end
        ddslc_pkg::H_LOW: begin
          if (tick) begin
            sclk_q  <= 1'b1;
            timer_q <= div_q;
            if (bitCnt_q == ddslc_pkg::LAST_BIT) begin
              state_q <= ddslc_pkg::H_TAIL;
            end else begin
              bitCnt_q <= bitCnt_q + 4'h1;
              out_q    <= {out_q[ddslc_pkg::WORD_W-2:0], 1'b0};
              data_q   <= out_q[ddslc_pkg::WORD_W-2];
              state_q  <= ddslc_pkg::H_HIGH;
            end
          end
        end
        ddslc_pkg::H_TAIL: begin
          if (tick) begin
            selN_q  <= 1'b1;
            data_q  <= 1'b0;
            timer_q <= ddslc_pkg::DIV_W'(ddslc_pkg::SYNC_HIGH_CYC) + div_q;
            state_q <= ddslc_pkg::H_GAP;
          end
        end
        ddslc_pkg::H_GAP: begin
          if (tick) begin
            state_q <= ddslc_pkg::H_IDLE;
          end
        end
        default: begin
          state_q <= ddslc_pkg::H_IDLE;
        end
      endcase
    end
  end

  // Link pins straight from flip-flops
  assign link.frameSelN = selN_q;
  assign link.serClk    = sclk_q;
  assign link.serData   = data_q;
endmodule

// >>> tb/ddslc_link_chk.sv
// Concurrent checks on the main serial link and its converter end.
// Assumes one clock domain; placed beside the link interface.
module ddslc_link_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       frameSelN,
  input wire logic       serClk,
  input wire logic       serData,
  input wire logic [9:0] channelAOutput_q,
  input wire logic [9:0] channelBOutput_q,
  input wire logic       powerDown_q,
  input wire logic       termHiZ_q,
  input wire logic       termPull2k5_q,
  input wire logic       termPull100k_q,
  input wire logic       frameDone_q
);
  logic [4:0]  fallCnt_q;
  logic [11:0] wakeCnt_q;
  logic        clkPrev_q;
  logic        pdPrev_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Previous levels for edge detection
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      clkPrev_q <= 1'b1;
      pdPrev_q  <= 1'b0;
    end else begin
      clkPrev_q <= serClk;
      pdPrev_q  <= powerDown_q;
    end
  end

  // Clock falls seen in the current frame
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fallCnt_q <= 5'h00;
    end else if (frameSelN) begin
      fallCnt_q <= 5'h00;
    end else if (clkPrev_q && !serClk && fallCnt_q != 5'h1f) begin
      fallCnt_q <= fallCnt_q + 5'h01;
    end
  end

  // Cycles since power-down was left
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wakeCnt_q <= 12'h000;
    end else if (pdPrev_q && !powerDown_q) begin
      wakeCnt_q <= 12'h001;
    end else if (wakeCnt_q != 12'h000 && wakeCnt_q != 12'hfff) begin
      wakeCnt_q <= wakeCnt_q + 12'h001;
    end
  end

  sequence s_first_fall;
    $fell(serClk) && !frameSelN && fallCnt_q == 5'h00;
  endsequence
  sequence s_last_fall;
    $fell(serClk) && !frameSelN && fallCnt_q == 5'h0f;
  endsequence

  a_sel_clk_apart: assert property ($fell(frameSelN) |-> !$fell(serClk))
    else $error("select fell with a clock fall");
  a_clk_in_frame: assert property ($fell(serClk) |-> !frameSelN)
    else $error("clock fall outside a frame");
  a_lead_zero: assert property (s_first_fall |-> !serData)
    else $error("first bit not zero");
  a_select_gap: assert property ($rose(frameSelN) |-> frameSelN [*3])
    else $error("select high time too short");
  a_whole_frame: assert property ($rose(frameSelN) |-> fallCnt_q == 5'h10)
    else $error("frame closed without sixteen falls");
  a_done_after_last: assert property (s_last_fall |-> ##[2:8] frameDone_q)
    else $error("no completion after last fall");
  a_done_single: assert property (frameDone_q |=> !frameDone_q [*8])
    else $error("second completion in one frame");
  a_mode_by_frame: assert property ($changed(powerDown_q) |-> ##[0:2] frameDone_q)
    else $error("mode changed without a frame");
  a_term_onehot: assert property (powerDown_q |->
      $onehot({termHiZ_q, termPull2k5_q, termPull100k_q}))
    else $error("termination not one-hot");
  a_term_clear: assert property (!powerDown_q |->
      {termHiZ_q, termPull2k5_q, termPull100k_q} == 3'h0)
    else $error("termination set while running");
  a_down_quiet: assert property (powerDown_q |->
      channelAOutput_q == 10'h000 && channelBOutput_q == 10'h000)
    else $error("output live in power-down");
  a_wake_quiet: assert property (wakeCnt_q != 12'h000 && wakeCnt_q < 12'h5dc |->
      channelAOutput_q == 10'h000 && channelBOutput_q == 10'h000)
    else $error("output live before wake ended");
  a_clk_low_min: assert property ($fell(serClk) |-> !serClk [*4])
    else $error("clock low phase too short");
  a_clk_high_min: assert property ($rose(serClk) && !frameSelN |-> serClk [*4])
    else $error("clock high phase too short");
endmodule

// >>> tb/test_dual_dac_serial_load_control.sv
// Bench: host end and converter end joined by one link, plus a second
// converter end whose link the bench drives itself, faults included.
// Assumes the package, interface and design files are compiled first.
module test_dual_dac_serial_load_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk;
  logic             sys_rst;
  logic             read;
  logic             write;
  logic [3:0]       address;
  logic [31:0]      writedata;
  logic [31:0]      rnd;
  logic [31:0]      rd;
  wire  [31:0]      readdata;
  wire              waitrequest;
  wire  [1:0][9:0]  outA;
  wire  [1:0][9:0]  outB;
  wire  [1:0]       pd;
  wire  [1:0]       tz;
  wire  [1:0]       t2;
  wire  [1:0]       t1;
  wire  [1:0]       done;
  int               mismatches;
  int               checked;
  int               seed;
  logic [9:0]       inA [2];
  logic [9:0]       inB [2];
  logic [9:0]       dacA [2];
  logic [9:0]       dacB [2];
  logic [2:0]       mTerm [2];
  logic             mPd [2];
  logic             waking [2];
  logic [23:0]      expQ [2][$];

  ddslc_link_if link();
  ddslc_link_if link2();

  ddslc_host i_ddslc_host (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .link(link.host));
  ddslc_dev i_ddslc_dev (.clk(clk), .sys_rst(sys_rst), .link(link.dev),
    .channelAOutput_q(outA[0]), .channelBOutput_q(outB[0]), .powerDown_q(pd[0]),
    .termHiZ_q(tz[0]), .termPull2k5_q(t2[0]), .termPull100k_q(t1[0]), .frameDone_q(done[0]));
  ddslc_dev i_ddslc_dev_b (.clk(clk), .sys_rst(sys_rst), .link(link2.dev),
    .channelAOutput_q(outA[1]), .channelBOutput_q(outB[1]), .powerDown_q(pd[1]),
    .termHiZ_q(tz[1]), .termPull2k5_q(t2[1]), .termPull100k_q(t1[1]), .frameDone_q(done[1]));
  ddslc_link_chk i_ddslc_link_chk (.clk(clk), .sys_rst(sys_rst),
    .frameSelN(link.frameSelN), .serClk(link.serClk), .serData(link.serData),
    .channelAOutput_q(outA[0]), .channelBOutput_q(outB[0]), .powerDown_q(pd[0]),
    .termHiZ_q(tz[0]), .termPull2k5_q(t2[0]), .termPull100k_q(t1[0]),
    .frameDone_q(done[0]));

  // System clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [23:0] got(input int d);
    return {pd[d], tz[d], t2[d], t1[d], outA[d], outB[d]};
  endfunction

  function automatic logic [23:0] pack(input int d);
    logic live;
    live = !mPd[d] && !waking[d];
    return {mPd[d], mTerm[d], live ? dacA[d] : 10'h000, live ? dacB[d] : 10'h000};
  endfunction

  task automatic cmp_out(input logic [23:0] e, input logic [23:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value at %0t: expected %h got %h", $time, e, g);
    end
  endtask

  // Reference model of one converter end; notes the expected outputs
  task automatic note(input int d, input logic [15:0] w);
    logic [9:0] c;
    c = w[11:2];
    case (w[13:12])
      2'h0: begin
        if (w[14]) inB[d] = c; else inA[d] = c;
      end
      2'h1: begin
        if (w[14]) inB[d] = c; else inA[d] = c;
        dacA[d] = inA[d];
        dacB[d] = inB[d];
      end
      2'h2: begin
        inA[d] = c;
        inB[d] = c;
        dacA[d] = c;
        dacB[d] = c;
      end
      default: begin
        mPd[d] = 1'b1;
        mTerm[d] = (w[15:14] == 2'h1) ? 3'h2 : (w[15:14] == 2'h2) ? 3'h1 : 3'h4;
      end
    endcase
    if (w[13:12] != 2'h3) begin
      waking[d] = mPd[d];
      mPd[d] = 1'b0;
      mTerm[d] = 3'h0;
    end
    expQ[d].push_back(pack(d));
  endtask

  // One Avalon-MM transfer; read data lands in rd
  task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] wd);
    @(posedge clk);
    address <= a;
    write <= wr;
    read <= !wr;
    writedata <= wd;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wait_idle();
    do begin
      bus(ddslc_pkg::REG_STAT, 1'b0, 32'h0);
    end while (rd[0] !== 1'b0);
    repeat (8) @(posedge clk);
  endtask

  task automatic send(input logic [15:0] w);
    bus(ddslc_pkg::REG_CMD, 1'b1, {16'h0000, w});
    note(0, {1'b0, w[14:0]});
    wait_idle();
  endtask

  // Bench-made frame on the second link, 125 ns clock, free phase
  task automatic frame2(input logic [15:0] w, input int falls);
    link2.frameSelN <= 1'b0;
    link2.serData <= w[15];
    #62.5;
    for (int i = 1; i <= falls; i++) begin
      link2.serClk <= 1'b0;
      #62.5;
      rnd = $random(seed);
      link2.serClk <= 1'b1;
      link2.serData <= (i < 16) ? w[15 - i] : rnd[0];
      #62.5;
    end
    link2.frameSelN <= 1'b1;
    link2.serData <= 1'b0;
    #500;
  endtask

  // Result monitors, one per converter end
  for (genvar g = 0; g < 2; g++) begin : g_mon
    always @(posedge clk) begin
      if (done[g] === 1'b1) begin
        repeat (2) @(posedge clk);
        #1;
        cmp_out(expQ[g].size() ? expQ[g].pop_front() : 24'hffffff, got(g));
      end
    end
  end

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #400000;
    mismatches++;
    test_done();
  end

  // Main sequence
  initial begin
    seed = 32'hae2b;
    for (int d = 0; d < 2; d++) begin
      inA[d] = 10'h000;
      inB[d] = 10'h000;
      dacA[d] = 10'h000;
      dacB[d] = 10'h000;
      mTerm[d] = 3'h0;
      mPd[d] = 1'b0;
      waking[d] = 1'b0;
    end
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0;
    link2.frameSelN = 1'b1;
    link2.serClk = 1'b1;
    link2.serData = 1'b0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    cmp_out(24'h000000, got(0));
    cmp_out(24'h000000, got(1));
    bus(ddslc_pkg::REG_DIV, 1'b0, 32'h0);
    cmp_rd({24'h0, ddslc_pkg::DIV_RST}, rd);
    bus(ddslc_pkg::REG_DIV, 1'b1, 32'h3);
    bus(4'hc, 1'b1, 32'hffffffff);
    bus(4'hc, 1'b0, 32'h0);
    cmp_rd(32'h0, rd);
    bus(ddslc_pkg::REG_DIV, 1'b0, 32'h0);
    cmp_rd({24'h0, ddslc_pkg::DIV_MIN}, rd);
    $display("register test done");
    for (int k = 0; k < 8; k++) begin
      rnd = $random(seed);
      send({rnd[15], k[2], k[1:0], (k == 0) ? 12'hfff : (k == 1) ? 12'h000 : rnd[11:0]});
      if (k == 4) begin
        repeat (1600) @(posedge clk);
        waking[0] = 1'b0;
        cmp_out(pack(0), got(0));
      end
    end
    $display("mode test done");
    bus(ddslc_pkg::REG_CMD, 1'b1, 32'h2ab0);
    note(0, 16'h2ab0);
    bus(ddslc_pkg::REG_CMD, 1'b1, 32'h1550);
    bus(ddslc_pkg::REG_STAT, 1'b0, 32'h0);
    cmp_rd(32'h3, {30'h0, rd[1:0]});
    wait_idle();
    bus(ddslc_pkg::REG_STAT, 1'b1, 32'h2);
    bus(ddslc_pkg::REG_STAT, 1'b0, 32'h0);
    cmp_rd(32'h0, {30'h0, rd[1:0]});
    $display("refusal test done");
    note(1, 16'h1abc);
    frame2(16'h1abc, 20);
    frame2(16'h2004, 10);
    cmp_out(pack(1), got(1));
    for (int j = 0; j < 4; j++) begin
      note(1, {j[1:0], 14'h3000});
      frame2({j[1:0], 14'h3000}, 16);
    end
    frame2(16'h1fff, 12);
    cmp_out(pack(1), got(1));
    note(1, 16'h0124);
    frame2(16'h0124, 16);
    repeat (1600) @(posedge clk);
    waking[1] = 1'b0;
    cmp_out(pack(1), got(1));
    $display("link fault test done");
    cmp_out(24'h0, 24'(expQ[0].size() + expQ[1].size()));
    test_done();
  end
endmodule
